/* include/asrc_defines.vh */
// Timing constants and geometry for the asynchronous static memory controller
`ifndef ASRC_DEFINES_VH
`define ASRC_DEFINES_VH
// ==========================================================
// Geometry
`define ASRC_ADDR_W 17
`define ASRC_DATA_W 8
// ==========================================================
// Clock period in ns
`define ASRC_CLK_NS 10
// ==========================================================
// Timing figures in ns, slowest grade as default
`define ASRC_READ_PERIOD_MIN_NS 120
`define ASRC_ADDRESS_TO_DATA_DELAY_NS 120
`define ASRC_OUTPUT_DRIVE_ACCESS_DELAY_NS 50
`define ASRC_DRIVE_OFF_TO_FLOAT_NS 40
`define ASRC_WRITE_PERIOD_MIN_NS 120
`define ASRC_WRITE_PULSE_MIN_NS 70
`define ASRC_ADDRESS_TO_WRITE_END_NS 85
`define ASRC_DATA_SETUP_TO_WRITE_END_NS 45
`define ASRC_WRITE_RECOVERY_MIN_NS 5
`define ASRC_RETENTION_EXIT_RECOVERY_NS 120
// ==========================================================
// Least times rounded up to whole cycles
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`endif

/* verilog/asrc_timer.v */
// Down-counting wait timer used for the float-turnaround wait of the controller
`timescale 1ns/1ps
module asrc_timer #(
  parameter W = 8
) (
  ref_clk,
  rst_n,
  load,
  load_value,
  done
);
  input wire ref_clk;
  input wire rst_n;
  input wire load;
  input wire [W-1:0] load_value;
  output reg done;

  reg [W-1:0] count;

  // ==========================================================
  // Counter
  // Done rises the cycle after count reaches one, so a load of N waits N cycles
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
      done <= 1'b1;
    end else if (load) begin
      count <= load_value;
      done <= (load_value == {W{1'b0}});
    end else if (count != {W{1'b0}}) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
      done <= (count == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule

/* verilog/asrc_ctrl.v */
// Host-side controller driving an asynchronous 128K x 8 static memory
// ==========================================================
// Overview of operation
// - Write strobe stays high during reads
// - Address valid no later than select assertion
// - Write cycle lasts at least write period
// - Write strobe held low for pulse minimum
// - Address and selects valid before write end
// - Write data valid setup before write end
// - Address steady for recovery after write
// - Never drive data while memory drives it
// - Wait one read period after retention exit
`timescale 1ns/1ps
`include "asrc_defines.vh"
module asrc_ctrl #(
  parameter AW = `ASRC_ADDR_W,
  parameter DW = `ASRC_DATA_W,
  parameter TW = 8
) (
  ref_clk,
  arst_n,
  req_valid,
  req_write,
  req_addr,
  req_wdata,
  req_ready,
  rsp_valid,
  rsp_rdata,
  retention_req,
  retention_active,
  mem_addr,
  select_one_n,
  select_two_high,
  output_enable_n,
  write_strobe_n,
  mem_data_in,
  mem_data_out,
  mem_data_oe
);
  input wire ref_clk;
  input wire arst_n;
  input wire req_valid;
  input wire req_write;
  input wire [AW-1:0] req_addr;
  input wire [DW-1:0] req_wdata;
  output reg req_ready;
  output reg rsp_valid;
  output reg [DW-1:0] rsp_rdata;
  input wire retention_req;
  output reg retention_active;
  output reg [AW-1:0] mem_addr;
  output reg select_one_n;
  output reg select_two_high;
  output reg output_enable_n;
  output reg write_strobe_n;
  input wire [DW-1:0] mem_data_in;
  output reg [DW-1:0] mem_data_out;
  output reg mem_data_oe;

  // ==========================================================
  // Least time in ns to whole cycles; cut to counter width on purpose
  function [TW-1:0] cyc_up;
    input integer ns;
    integer cycles;
    begin
      cycles = `ASRC_CYC_UP(ns);
      cyc_up = cycles[TW-1:0];
    end
  endfunction

  // Cycle counts, least times rounded up
  localparam [TW-1:0] RD_ACCESS = cyc_up(`ASRC_ADDRESS_TO_DATA_DELAY_NS);
  localparam [TW-1:0] RD_PERIOD = cyc_up(`ASRC_READ_PERIOD_MIN_NS);
  localparam [TW-1:0] OE_ACCESS = cyc_up(`ASRC_OUTPUT_DRIVE_ACCESS_DELAY_NS);
  localparam [TW-1:0] FLOAT_WAIT = cyc_up(`ASRC_DRIVE_OFF_TO_FLOAT_NS);
  localparam [TW-1:0] WR_PULSE = cyc_up(`ASRC_WRITE_PULSE_MIN_NS);
  localparam [TW-1:0] WR_ADDR_END = cyc_up(`ASRC_ADDRESS_TO_WRITE_END_NS);
  localparam [TW-1:0] WR_DATA_END = cyc_up(`ASRC_DATA_SETUP_TO_WRITE_END_NS);
  localparam [TW-1:0] WR_RECOVER = cyc_up(`ASRC_WRITE_RECOVERY_MIN_NS);
  localparam [TW-1:0] WR_PERIOD = cyc_up(`ASRC_WRITE_PERIOD_MIN_NS);
  localparam [TW-1:0] RET_RECOVER = cyc_up(`ASRC_RETENTION_EXIT_RECOVERY_NS);

  // ==========================================================
  // States
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD = 3'h1;
  localparam [2:0] ST_RD_END = 3'h2;
  localparam [2:0] ST_WR_SETUP = 3'h3;
  localparam [2:0] ST_WR = 3'h4;
  localparam [2:0] ST_WR_END = 3'h5;
  localparam [2:0] ST_RET = 3'h6;
  localparam [2:0] ST_RET_EXIT = 3'h7;

  // Larger of two counts
  function [TW-1:0] max_cyc;
    input [TW-1:0] a;
    input [TW-1:0] b;
    begin
      max_cyc = (a > b) ? a : b;
    end
  endfunction

  // Write low time must satisfy pulse, address and data setup together
  localparam [TW-1:0] WR_LOW = (WR_PULSE > WR_ADDR_END) ?
    ((WR_PULSE > WR_DATA_END) ? WR_PULSE : WR_DATA_END) :
    ((WR_ADDR_END > WR_DATA_END) ? WR_ADDR_END : WR_DATA_END);

  reg rst_meta;
  reg rst_n;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [TW-1:0] cycle_count;
  reg [TW-1:0] next_cycle_count;
  reg tmr_load;
  reg [TW-1:0] tmr_value;
  wire tmr_done;

  // ==========================================================
  // Reset release through two flip-flops
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Float-turnaround wait after reads; one shared timer
  asrc_timer #(.W(TW)) u_turn (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .load_value(tmr_value),
    .done(tmr_done)
  );

  // ==========================================================
  // Next-state logic
  always @* begin
    next_state = state;
    next_cycle_count = cycle_count + {{(TW-1){1'b0}}, 1'b1};
    tmr_load = 1'b0;
    tmr_value = FLOAT_WAIT;
    case (state)
      ST_IDLE: begin
        next_cycle_count = {TW{1'b0}};
        if (retention_req) begin
          next_state = ST_RET;
        end else if (req_valid && req_ready) begin
          // Write waits until memory outputs have floated
          next_state = req_write ? ST_WR_SETUP : ST_RD;
        end
      end
      ST_RD: begin
        // Sample after both address and enable access times
        if (cycle_count + {{(TW-1){1'b0}}, 1'b1} >= max_cyc(RD_ACCESS, OE_ACCESS)) begin
          next_state = ST_RD_END;
        end
      end
      ST_RD_END: begin
        // Hold cycle to fill read period, then deselect with float wait
        if (cycle_count + {{(TW-1){1'b0}}, 1'b1} >= RD_PERIOD) begin
          next_state = ST_IDLE;
          tmr_load = 1'b1;
        end
      end
      ST_WR_SETUP: begin
        if (tmr_done) begin
          next_state = ST_WR;
          next_cycle_count = {TW{1'b0}};
        end
      end
      ST_WR: begin
        // Strobe low long enough for pulse, address and data setup
        if (cycle_count + {{(TW-1){1'b0}}, 1'b1} >= WR_LOW) begin
          next_state = ST_WR_END;
          next_cycle_count = {TW{1'b0}};
        end
      end
      ST_WR_END: begin
        // Address held for recovery and whole write period
        if ((cycle_count + {{(TW-1){1'b0}}, 1'b1} >= WR_RECOVER) &&
            (cycle_count + WR_LOW + {{(TW-1){1'b0}}, 1'b1} >= WR_PERIOD)) begin
          next_state = ST_IDLE;
        end
      end
      ST_RET: begin
        next_cycle_count = {TW{1'b0}};
        if (!retention_req) begin
          next_state = ST_RET_EXIT;
        end
      end
      ST_RET_EXIT: begin
        // No access for a read period after retention
        if (cycle_count + {{(TW-1){1'b0}}, 1'b1} >= RET_RECOVER) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State and memory pins, all registered
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cycle_count <= {TW{1'b0}};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
      retention_active <= 1'b0;
      mem_addr <= {AW{1'b0}};
      select_one_n <= 1'b1;
      select_two_high <= 1'b0;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      mem_data_out <= {DW{1'b0}};
      mem_data_oe <= 1'b0;
    end else begin
      state <= next_state;
      cycle_count <= next_cycle_count;
      rsp_valid <= 1'b0;
      req_ready <= (next_state == ST_IDLE) && !retention_req;
      retention_active <= (next_state == ST_RET);
      if (state == ST_IDLE && req_valid && req_ready && !retention_req) begin
        // Address placed with selects, never after
        mem_addr <= req_addr;
        mem_data_out <= req_wdata;
      end
      case (next_state)
        ST_RD, ST_RD_END: begin
          // Selected read: strobe high, enable low, bus released
          select_one_n <= 1'b0;
          select_two_high <= 1'b1;
          output_enable_n <= 1'b0;
          write_strobe_n <= 1'b1;
          mem_data_oe <= 1'b0;
        end
        ST_WR_SETUP: begin
          // Selected, enable off, not yet driving
          select_one_n <= 1'b0;
          select_two_high <= 1'b1;
          output_enable_n <= 1'b1;
          write_strobe_n <= 1'b1;
          mem_data_oe <= 1'b0;
        end
        ST_WR: begin
          // Strobe low floats memory outputs, so drive data
          select_one_n <= 1'b0;
          select_two_high <= 1'b1;
          output_enable_n <= 1'b1;
          write_strobe_n <= 1'b0;
          mem_data_oe <= 1'b1;
        end
        ST_WR_END: begin
          // Strobe ends write; data dropped at once since hold is zero
          select_one_n <= 1'b0;
          select_two_high <= 1'b1;
          output_enable_n <= 1'b1;
          write_strobe_n <= 1'b1;
          mem_data_oe <= 1'b0;
        end
        default: begin
          // Deselected: memory floats, retention may start at once
          select_one_n <= 1'b1;
          select_two_high <= 1'b0;
          output_enable_n <= 1'b1;
          write_strobe_n <= 1'b1;
          mem_data_oe <= 1'b0;
        end
      endcase
      // Capture before address moves; old data is still held
      if (state == ST_RD && next_state == ST_RD_END) begin
        rsp_rdata <= mem_data_in;
        rsp_valid <= 1'b1;
      end
    end
  end
endmodule

/* test/asrc_ctrl_sva.sv */
// Assertions on the memory pins and request ready of asrc_ctrl
`timescale 1ns/1ps
// ====
// Pin checker
module asrc_ctrl_sva #(
  parameter AW = 17,
  parameter DW = 8
) (
  input wire ref_clk,
  input wire arst_n,
  input wire req_ready,
  input wire rsp_valid,
  input wire retention_req,
  input wire retention_active,
  input wire [AW-1:0] mem_addr,
  input wire select_one_n,
  input wire select_two_high,
  input wire output_enable_n,
  input wire write_strobe_n,
  input wire [DW-1:0] mem_data_out,
  input wire mem_data_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Both selects active
  wire sel_on = !select_one_n && select_two_high;
  chk_read_no_strobe:
    assert property (!output_enable_n |-> write_strobe_n)
    else $error("strobe low in read");
  chk_addr_held:
    assert property (sel_on && $past(sel_on) |-> $stable(mem_addr))
    else $error("address moved while selected");
  chk_strobe_width:
    assert property ($fell(write_strobe_n) |-> !write_strobe_n [*7])
    else $error("strobe pulse short");
  chk_data_steady:
    assert property (!write_strobe_n && !$past(write_strobe_n) |-> mem_data_oe && $stable(mem_data_out))
    else $error("data moved under strobe");
  chk_select_span:
    assert property ($rose(write_strobe_n) |-> $past(sel_on) && $past(sel_on, 9))
    else $error("select span short");
  chk_write_period:
    assert property ($fell(write_strobe_n) |=> $stable(mem_addr) [*8] ##1 $stable(mem_addr) [*3])
    else $error("write cycle short");
  chk_float_wait:
    assert property ($rose(mem_data_oe) |-> $past(output_enable_n) && $past(output_enable_n, 4))
    else $error("drive before float");
  chk_retention_exit:
    assert property ($fell(retention_req) && retention_active |-> !req_ready [*8] ##1 !req_ready [*4])
    else $error("access too soon after retention");
  cov_read: cover property (rsp_valid);
  cov_write: cover property ($rose(write_strobe_n));
  cov_retention: cover property ($fell(retention_req) && retention_active);
endmodule

bind asrc_ctrl asrc_ctrl_sva #(.AW(AW), .DW(DW)) i_asrc_ctrl_sva (.ref_clk(ref_clk), .arst_n(arst_n),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .retention_req(retention_req),
  .retention_active(retention_active), .mem_addr(mem_addr), .select_one_n(select_one_n),
  .select_two_high(select_two_high), .output_enable_n(output_enable_n),
  .write_strobe_n(write_strobe_n), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));

/* test/asrc_sram_model.sv */
// Behavioural model of the 128K x 8 asynchronous static memory
`timescale 1ns/1ps
// ====
// Memory device
module asrc_sram_model #(
  parameter real T_AA = 120.0,
  parameter real T_OE = 50.0,
  parameter real T_OH = 10.0,
  parameter real T_HZ = 40.0
) (
  input wire [16:0] addr,
  input wire one_n,
  input wire two_high,
  input wire oe_n,
  input wire we_n,
  input wire [7:0] din,
  input wire din_oe,
  output logic [7:0] dq,
  output logic clash
);
  logic [7:0] mem [0:131071];
  logic [7:0] last = 8'h00;
  logic [7:0] din_d;
  logic wr_q = 1'b0;
  logic seen_clash = 1'b0;
  realtime t_a = 0, t_s = 0, t_o = 0, t_off = -100, n;
  wire sel = !one_n && two_high;
  wire rd = sel && !oe_n && we_n;
  // Zero hold: keep the data from just before the write ends; undriven pins read inverted
  assign #0.001 din_d = din_oe ? din : ~din;
  assign clash = seen_clash;
  // Event times for access and float limits
  always @(addr) t_a = $realtime;
  always @(posedge sel) t_s = $realtime;
  always @(negedge oe_n) t_o = $realtime;
  always @(negedge rd) t_off = $realtime;
  // Write lands when strobe or select ends it
  always @(sel or we_n) begin
    if (wr_q && !(sel && !we_n)) mem[addr] = din_d;
    wr_q = sel && !we_n;
  end
  // Controller drive while outputs still on
  always @(posedge din_oe) if (rd || $realtime - t_off < T_HZ) seen_clash = 1'b1;
  // Polled off the clock edges; toggling stands for undefined data
  initial begin
    dq = 8'h00;
    #0.5;
    forever begin
      n = $realtime + 0.5;
      if (rd && n - t_a >= T_AA && n - t_s >= T_AA && n - t_o >= T_OE) begin
        dq = mem[addr];
        last = dq;
      end else if (rd && n - t_a < T_OH) dq = last;
      else dq = ~dq;
      #1;
    end
  end
endmodule

/* test/asrc_ctrl_tb_top.sv */
// Self-checking testbench for asrc_ctrl against a memory model
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t %h %h", $time, g, e); end end
// ====
// Bench top
module asrc_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [16:0] req_addr = 17'h00000;
  logic [7:0] req_wdata = 8'h00;
  logic retention_req = 1'b0;
  wire req_ready, rsp_valid, retention_active, select_one_n, select_two_high;
  wire output_enable_n, write_strobe_n, mem_data_oe, clash;
  wire [7:0] rsp_rdata, mem_data_out, dq;
  wire [16:0] mem_addr;
  // Shared data pins
  wire [7:0] mem_data_in = mem_data_oe ? mem_data_out : dq;
  int fails = 0;
  int cmp_count = 0;
  int waited;
  logic [7:0] ref_mem [int];
  asrc_ctrl i_asrc_ctrl (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retention_req(retention_req),
    .retention_active(retention_active), .mem_addr(mem_addr), .select_one_n(select_one_n),
    .select_two_high(select_two_high), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe));
  asrc_sram_model i_asrc_sram_model (.addr(mem_addr), .one_n(select_one_n), .two_high(select_two_high),
    .oe_n(output_enable_n), .we_n(write_strobe_n), .din(mem_data_out), .din_oe(mem_data_oe),
    .dq(dq), .clash(clash));
  // Clock
  initial forever #5 ref_clk = ~ref_clk;
  // Expected byte for a written address
  function automatic logic [7:0] exp_rd(input logic [16:0] a);
    return ref_mem[a];
  endfunction
  // Verdict
  task automatic complete_run;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One request held until taken; a read then waits for its byte
  task automatic xfer(input logic wr, input logic [16:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    waited = 0;
    do begin
      @(posedge ref_clk);
      waited++;
    end while (req_ready !== 1'b1 && waited < 400);
    req_valid <= 1'b0;
    if (wr) ref_mem[a] = d;
    else begin
      repeat (20) begin
        @(posedge ref_clk);
        if (rsp_valid === 1'b1) break;
      end
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_rdata, exp_rd(a))
    end
  endtask
  // Main sequence
  initial begin
    logic [16:0] a;
    logic [7:0] d;
    void'($urandom(32'h7DF06A93));
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    // Range ends, overwrite, write right after read
    xfer(1'b1, 17'h00000, 8'hA5);
    xfer(1'b1, 17'h1FFFF, 8'h5A);
    xfer(1'b0, 17'h1FFFF, 8'h00);
    xfer(1'b1, 17'h1FFFF, 8'hC3);
    xfer(1'b0, 17'h1FFFF, 8'h00);
    xfer(1'b0, 17'h00000, 8'h00);
    // Retention, then a read that must wait out the recovery
    @(posedge ref_clk);
    retention_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK(retention_active, 1'b1)
    retention_req <= 1'b0;
    xfer(1'b0, 17'h00000, 8'h00);
    `CHK(waited >= 12, 1'b1)
    // Reset in mid-run while idle: pins back to deselected, stored bytes kept
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK({select_one_n, select_two_high, write_strobe_n, mem_data_oe}, 4'hA)
    arst_n <= 1'b1;
    xfer(1'b0, 17'h00000, 8'h00);
    // Random mix; reads only hit written places
    repeat (40) begin
      a = 17'($urandom_range(0, 131071));
      d = 8'($urandom);
      xfer(1'b1, a, d);
      if ($urandom_range(0, 1) == 1) xfer(1'b0, a, 8'h00);
    end
    `CHK(clash, 1'b0)
    complete_run;
  end
  // Watchdog well above the expected run
  initial begin
    #200us;
    fails++;
    complete_run;
  end
endmodule
